// >>> verilog/ais_consts.vh
// Constants for the analog input scaling block.
`ifndef AIS_CONSTS_VH
`define AIS_CONSTS_VH

// ==========================================================================
// Object indices and their byte addresses (index times four).
`define AIS_IDX_READING      16'h3320
`define AIS_IDX_OFFSET       16'h3321
`define AIS_IDX_DIVISOR      16'h3322
`define AIS_ADDR_READING     {2'b00, `AIS_IDX_READING} * 18'h00004
`define AIS_ADDR_OFFSET      {2'b00, `AIS_IDX_OFFSET} * 18'h00004
`define AIS_ADDR_DIVISOR     {2'b00, `AIS_IDX_DIVISOR} * 18'h00004

// ==========================================================================
// Per-channel value words.
`define AIS_ADDR_READING_CH0 18'h00100
`define AIS_ADDR_READING_CH1 18'h00104
`define AIS_ADDR_OFFSET_CH0  18'h00108
`define AIS_ADDR_OFFSET_CH1  18'h0010C
`define AIS_ADDR_DIVISOR_CH0 18'h00110
`define AIS_ADDR_DIVISOR_CH1 18'h00114

// ==========================================================================
// Reset values and fixed figures.
`define AIS_CHANNEL_COUNT    32'h00000002
`define AIS_RST_READING      32'h00000000
`define AIS_RST_OFFSET       32'h00000000
`define AIS_RST_DIVISOR      32'h00000001
`define AIS_DIV_STEPS        6'h21
`define AIS_RAW_WIDTH        10

// ==========================================================================
// Bus responses.
`define AIS_RESP_OKAY        2'b00
`define AIS_RESP_SLVERR      2'b10

`endif

// >>> verilog/ais_scaling.v
// Analog input scaling: offset plus signed division per channel, AXI4-Lite registers.
//
// Functional notes
// - Two channels; each set reports count two.
// - Readings are signed 32-bit, read only.
// - Offset added to raw value before division.
// - Sum divided by divisor, quotient stored.
// - Offsets reset to zero, read/write.
// - Divisors reset to one, read/write.
// - Default offset and divisor give raw counts.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "ais_consts.vh"

module ais_scaling
(
    // Clock and reset.
    input  wire        i_core_clk,
    input  wire        i_rstn,
    // Raw converter samples, same clock.
    input  wire [9:0]  i_raw_ch0,
    input  wire [9:0]  i_raw_ch1,
    input  wire        i_raw_valid,
    // AXI4-Lite write address and data.
    input  wire [17:0] i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    // AXI4-Lite write response.
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    // AXI4-Lite read.
    input  wire [17:0] i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // Published readings.
    output reg  [31:0] o_reading_ch0,
    output reg  [31:0] o_reading_ch1
);

    localparam [1:0] ST_LOAD  = 2'h0;
    localparam [1:0] ST_DIV   = 2'h1;
    localparam [1:0] ST_STORE = 2'h2;
    localparam [2:0] SEL_NONE    = 3'h0;
    localparam [2:0] SEL_COUNT   = 3'h1;
    localparam [2:0] SEL_READING = 3'h2;
    localparam [2:0] SEL_OFFSET  = 3'h3;
    localparam [2:0] SEL_DIVISOR = 3'h4;

    // ======================================================================
    // Address decode, shared by the read and write paths.
    // Returns the register kind in bits 3:1 and the channel in bit 0.
    function [3:0] decode;
        input [17:0] addr;
        begin
            case (addr)
                `AIS_ADDR_READING, `AIS_ADDR_OFFSET, `AIS_ADDR_DIVISOR:
                    decode = {SEL_COUNT, 1'b0};
                `AIS_ADDR_READING_CH0: decode = {SEL_READING, 1'b0};
                `AIS_ADDR_READING_CH1: decode = {SEL_READING, 1'b1};
                `AIS_ADDR_OFFSET_CH0:  decode = {SEL_OFFSET, 1'b0};
                `AIS_ADDR_OFFSET_CH1:  decode = {SEL_OFFSET, 1'b1};
                `AIS_ADDR_DIVISOR_CH0: decode = {SEL_DIVISOR, 1'b0};
                `AIS_ADDR_DIVISOR_CH1: decode = {SEL_DIVISOR, 1'b1};
                default:               decode = {SEL_NONE, 1'b0};
            endcase
        end
    endfunction

    // Merges a strobed write into an old word.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (strb[k])
                    merge[k*8 +: 8] = data[k*8 +: 8];
        end
    endfunction

    // ======================================================================
    // Configuration and sample storage.
    reg [31:0] offset  [0:1];
    reg [31:0] divisor [0:1];
    reg [9:0]  raw     [0:1];
    reg        aw_full;
    reg        w_full;
    reg [17:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    wire [3:0]  wr_sel  = decode(awaddr_q);
    wire        wr_ch   = wr_sel[0];
    wire [31:0] off_new = merge(offset[wr_ch], wdata_q, wstrb_q);
    wire [31:0] div_new = merge(divisor[wr_ch], wdata_q, wstrb_q);
    wire        wr_go   = aw_full && w_full && !o_bvalid;
    wire [3:0]  rd_sel  = decode(i_araddr);

    // Raw samples are unsigned 10-bit counts spanning the full input range.
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            raw[0] <= 10'h000;
            raw[1] <= 10'h000;
        end
        else if (i_raw_valid)
        begin
            raw[0] <= i_raw_ch0;
            raw[1] <= i_raw_ch1;
        end
    end

    // ======================================================================
    // Write channel: address and data taken in either order.
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_awready  <= 1'b1;
            o_wready   <= 1'b1;
            aw_full    <= 1'b0;
            w_full     <= 1'b0;
            awaddr_q   <= 18'h00000;
            wdata_q    <= 32'h00000000;
            wstrb_q    <= 4'h0;
            o_bvalid   <= 1'b0;
            o_bresp    <= `AIS_RESP_OKAY;
            offset[0]  <= `AIS_RST_OFFSET;
            offset[1]  <= `AIS_RST_OFFSET;
            divisor[0] <= `AIS_RST_DIVISOR;
            divisor[1] <= `AIS_RST_DIVISOR;
        end
        else
        begin
            if (o_awready && i_awvalid)
            begin
                aw_full   <= 1'b1;
                awaddr_q  <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (o_wready && i_wvalid)
            begin
                w_full   <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_full  <= 1'b0;
                w_full   <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp  <= `AIS_RESP_SLVERR; // Read-only and zero writes stay refused.
                if (wr_sel[3:1] == SEL_OFFSET)
                begin
                    offset[wr_ch] <= off_new;
                    o_bresp       <= `AIS_RESP_OKAY;
                end
                else if (wr_sel[3:1] == SEL_DIVISOR && div_new != 32'h00000000)
                begin
                    divisor[wr_ch] <= div_new;
                    o_bresp        <= `AIS_RESP_OKAY;
                end
            end
            if (o_bvalid && i_bready)
            begin
                o_bvalid  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // ======================================================================
    // Read channel: answer one cycle after the address is taken.
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h00000000;
            o_rresp   <= `AIS_RESP_OKAY;
        end
        else if (o_arready && i_arvalid)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rresp   <= `AIS_RESP_OKAY;
            case (rd_sel[3:1])
                SEL_COUNT:   o_rdata <= `AIS_CHANNEL_COUNT;
                SEL_READING: o_rdata <= rd_sel[0] ? o_reading_ch1 : o_reading_ch0;
                SEL_OFFSET:  o_rdata <= offset[rd_sel[0]];
                SEL_DIVISOR: o_rdata <= divisor[rd_sel[0]];
                default:
                begin
                    o_rdata <= 32'h00000000;
                    o_rresp <= `AIS_RESP_SLVERR;
                end
            endcase
        end
        else if (o_rvalid && i_rready)
        begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ======================================================================
    // Scaling engine: channels alternate through one restoring divider.
    reg  [1:0]  state;
    reg         ch;
    reg  [5:0]  steps;
    reg  [32:0] quo;
    reg  [33:0] rem;
    reg  [31:0] dvs_mag;
    reg         neg;
    wire [31:0]        off_sel = offset[ch];
    wire [31:0]        div_sel = divisor[ch];
    wire signed [32:0] sum     = $signed({23'h000000, raw[ch]})
                               + $signed({off_sel[31], off_sel});
    wire [32:0]        sum_mag = sum[32] ? (33'h000000000 - sum) : sum;
    wire [31:0]        div_mag = div_sel[31] ? (32'h00000000 - div_sel) : div_sel;
    wire [33:0]        rem_sh  = {rem[32:0], quo[32]};
    wire [33:0]        rem_sub = rem_sh - {2'b00, dvs_mag};
    wire [32:0]        q_sign  = neg ? (33'h000000000 - quo) : quo;
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state         <= ST_LOAD;
            ch            <= 1'b0;
            steps         <= 6'h00;
            quo           <= 33'h000000000;
            rem           <= 34'h000000000;
            dvs_mag       <= 32'h00000000;
            neg           <= 1'b0;
            o_reading_ch0 <= `AIS_RST_READING;
            o_reading_ch1 <= `AIS_RST_READING;
        end
        else
        begin
            case (state)
                ST_LOAD:
                begin
                    quo     <= sum_mag;
                    rem     <= 34'h000000000;
                    dvs_mag <= div_mag;
                    neg     <= sum[32] ^ div_sel[31];
                    steps   <= `AIS_DIV_STEPS;
                    state   <= ST_DIV;
                end
                ST_DIV:
                begin
                    if (!rem_sub[33])
                    begin
                        rem <= rem_sub;
                        quo <= {quo[31:0], 1'b1};
                    end
                    else
                    begin
                        rem <= rem_sh;
                        quo <= {quo[31:0], 1'b0};
                    end
                    steps <= steps - 6'h01;
                    if (steps == 6'h01)
                        state <= ST_STORE;
                end
                ST_STORE:
                begin
                    // Quotient truncates toward zero.
                    if (ch)
                        o_reading_ch1 <= q_sign[31:0];
                    else
                        o_reading_ch0 <= q_sign[31:0];
                    ch    <= ~ch;
                    state <= ST_LOAD;
                end
                default:
                    state <= ST_LOAD;
            endcase
        end
    end

endmodule

// >>> tb/ais_scaling_checker.sv
// Concurrent checks on the ports of the analog input scaling block.
`timescale 1ns/1ps
module ais_scaling_checker
(
    // Clock and reset.
    input wire logic        i_core_clk,
    input wire logic        i_rstn,
    // Register bus.
    input wire logic [17:0] i_awaddr,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0]  i_wstrb,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic [17:0] i_araddr,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    // Readings.
    input wire logic [31:0] o_reading_ch0,
    input wire logic [31:0] o_reading_ch1
);
    logic [17:0] aw_q;
    logic [31:0] w_q;
    logic [3:0]  s_q;
    logic        mod0;
    logic        mod1;
    // A channel counts as modified once any offset or divisor write to it is taken.
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            {aw_q, w_q, s_q, mod0, mod1} <= '0;
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_q <= i_awaddr;
                mod0 <= mod0 | (i_awaddr == 18'h00108) | (i_awaddr == 18'h00110);
                mod1 <= mod1 | (i_awaddr == 18'h0010C) | (i_awaddr == 18'h00114);
            end
            if (i_wvalid && o_wready)
                {w_q, s_q} <= {i_wdata, i_wstrb};
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    count_read_a: assert property (
        i_arvalid && o_arready && (i_araddr inside {18'h0CC80, 18'h0CC84, 18'h0CC88})
        |=> o_rvalid && o_rdata == 32'h2) else $error("channel count wrong");
    ro_write_a: assert property (
        $rose(o_bvalid) && (aw_q == 18'h00100 || aw_q == 18'h00104) |-> o_bresp == 2'h2)
        else $error("reading write accepted");
    zero_div_a: assert property (
        $rose(o_bvalid) && aw_q[17:3] == 15'h0022 && w_q == 32'h0 && s_q == 4'hF
        |-> o_bresp == 2'h2) else $error("zero divisor accepted");
    raw_range_a: assert property (
        !mod0 |-> o_reading_ch0 <= 32'h3FF) else $error("default reading not raw");
    refresh_gap_a: assert property (
        $changed(o_reading_ch0) |=> $stable(o_reading_ch0) [*8]) else $error("reading too fast");
    chan_alt_a: assert property (
        $changed(o_reading_ch0) |-> $stable(o_reading_ch1)) else $error("channels stored together");
    write_resp_a: assert property (
        i_awvalid && o_awready && i_wvalid && o_wready |=> !o_awready && !o_wready ##1 o_bvalid)
        else $error("write response late");
    read_resp_a: assert property (
        i_arvalid && o_arready |=> o_rvalid && !o_arready) else $error("read response late");
endmodule
bind ais_scaling ais_scaling_checker i_ais_scaling_checker (.*);

// >>> tb/ais_adc_model.sv
// Behavioural converter model feeding raw counts to the scaling block.
`timescale 1ns/1ps
module ais_adc_model
(
    // Clock and reset.
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    // Levels to convert and pace.
    input  wire logic [9:0] i_level0,
    input  wire logic [9:0] i_level1,
    input  wire logic       i_slow,
    // Raw samples.
    output wire logic [9:0] o_raw_ch0,
    output wire logic [9:0] o_raw_ch1,
    output wire logic       o_raw_valid
);
    logic [2:0] pace;
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            pace <= 3'h0;
        else
            pace <= (pace == 3'h4) ? 3'h0 : pace + 3'h1;
    end
    // Slow pace strobes one cycle in five; between strobes the lines carry inverted data.
    assign o_raw_valid = !i_slow || (pace == 3'h0);
    assign o_raw_ch0   = o_raw_valid ? i_level0 : ~i_level0;
    assign o_raw_ch1   = o_raw_valid ? i_level1 : ~i_level1;
endmodule

// >>> tb/test_ais_scaling.sv
// Self-checking testbench for the analog input scaling block.
`timescale 1ns/1ps
`include "ais_consts.vh"
module test_ais_scaling;
    logic        clk = 1'b0, rstn = 1'b0, slow = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [17:0] awaddr = 18'h0, araddr = 18'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hF;
    logic [9:0]  lvl0 = 10'h0, lvl1 = 10'h0;
    wire  [9:0]  raw0, raw1;
    wire         rawv, awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata, rd0, rd1;
    int          err_total = 0, checked = 0, cycles = 0;
    ais_adc_model i_ais_adc_model
    (
        .i_core_clk(clk), .i_rstn(rstn), .i_level0(lvl0), .i_level1(lvl1), .i_slow(slow),
        .o_raw_ch0(raw0), .o_raw_ch1(raw1), .o_raw_valid(rawv)
    );
    ais_scaling i_ais_scaling
    (
        .i_core_clk(clk), .i_rstn(rstn), .i_raw_ch0(raw0), .i_raw_ch1(raw1),
        .i_raw_valid(rawv), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(1'b1), .o_reading_ch0(rd0), .o_reading_ch1(rd1)
    );
    always #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [31:0] scale(input logic [9:0] r, input int o, input int d);
        return (int'(r) + o) / d;
    endfunction
    // Both channels of a write are offered together and each is dropped once taken.
    task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] e);
        logic ta, tw, da, dw;
        {da, dw} = 2'b00;
        {awaddr, wdata, wstrb, awvalid, wvalid} <= {a, d, s, 2'b11};
        while (!(da && dw))
        begin
            @(negedge clk);
            {ta, tw} = {awready & !da, wready & !dw};
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            {da, dw} = {da | ta, dw | tw};
        end
        do @(negedge clk); while (!bvalid);
        chk(bresp, e);
        @(posedge clk);
    endtask
    task automatic rd(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] e);
        {araddr, arvalid} <= {a, 1'b1};
        do @(negedge clk); while (!arready);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (!rvalid);
        chk(rdata, ed);
        chk(rresp, e);
        @(posedge clk);
    endtask
    initial
    begin
        int o0, o1, d0, d1;
        void'($urandom(32'h221DE5FD));
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        lvl0 <= 10'($urandom);
        lvl1 <= 10'($urandom);
        @(posedge clk);
        wr(18'h0CC84, 32'h7, 4'hF, 2'h2);
        for (int i = 0; i < 3; i++) rd(18'h0CC80 + 18'(4 * i), 32'h2, 2'h0);
        rd(`AIS_ADDR_OFFSET_CH1, 32'h0, 2'h0);
        rd(`AIS_ADDR_DIVISOR_CH1, 32'h1, 2'h0);
        repeat (160) @(posedge clk);
        rd(`AIS_ADDR_READING_CH1, 32'(lvl1), 2'h0);
        wr(`AIS_ADDR_READING_CH0, 32'h5A5A, 4'hF, 2'h2);
        rd(`AIS_ADDR_READING_CH0, 32'(lvl0), 2'h0);
        wr(18'h00200, 32'h1, 4'hF, 2'h2);
        rd(18'h00200, 32'h0, 2'h2);
        wr(`AIS_ADDR_DIVISOR_CH0, 32'h0, 4'hF, 2'h2);
        wr(`AIS_ADDR_DIVISOR_CH0, 32'h0, 4'h1, 2'h2);
        wr(`AIS_ADDR_DIVISOR_CH0, 32'h300, 4'h2, 2'h0);
        rd(`AIS_ADDR_DIVISOR_CH0, 32'h301, 2'h0);
        for (int n = 0; n < 8; n++)
        begin
            slow <= n[0];
            lvl0 <= (n == 0) ? 10'h3FF : 10'($urandom);
            lvl1 <= 10'($urandom);
            o0 = (n == 0) ? -2000 : int'($urandom_range(2000)) - 1000;
            o1 = int'($urandom_range(2000)) - 1000;
            d0 = (n == 0) ? 7 : (n == 1) ? -1 : int'($urandom_range(64)) - 32;
            if (d0 == 0) d0 = 3;
            d1 = n[1] ? -int'($urandom_range(4000)) - 1 : int'($urandom_range(4000)) + 1;
            wr(`AIS_ADDR_OFFSET_CH0, o0, 4'hF, 2'h0);
            wr(`AIS_ADDR_OFFSET_CH1, o1, 4'hF, 2'h0);
            wr(`AIS_ADDR_DIVISOR_CH0, d0, 4'hF, 2'h0);
            wr(`AIS_ADDR_DIVISOR_CH1, d1, 4'hF, 2'h0);
            repeat (160) @(posedge clk);
            chk(rd0, scale(lvl0, o0, d0));
            chk(rd1, scale(lvl1, o1, d1));
            rd(`AIS_ADDR_READING_CH1, scale(lvl1, o1, d1), 2'h0);
        end
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(`AIS_ADDR_OFFSET_CH0, 32'h0, 2'h0);
        rd(`AIS_ADDR_DIVISOR_CH1, 32'h1, 2'h0);
        test_done();
    end
endmodule
